// >>> rtl/ild_input_level_detector.sv
`timescale 1ns/1ps
module ild_input_level_detector (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Microport, synchronous to the sample clock.
	input wire logic select_lower_half_n_i,
	input wire logic [2:0] up_addr_i,
	input wire logic up_wr_i,
	input wire logic up_rd_i,
	input wire logic [7:0] up_wdata_i,
	output logic [7:0] up_rdata_o,
	// Port A input and indicators.
	input wire logic [9:0] port_a_sample_i,
	input wire logic port_a_input_select_i,
	output logic port_a_level_out_first_o,
	output logic port_a_level_out_second_o,
	// Port B input and indicators.
	input wire logic [9:0] port_b_sample_i,
	input wire logic port_b_input_select_i,
	output logic port_b_level_out_first_o,
	output logic port_b_level_out_second_o
);

	logic [7:0] sleep_reg, sleep_next;
	logic [7:0] channel_addr_pointer_reg, channel_addr_pointer_next;
	logic [7:0] stage1_reg, stage1_next;
	logic [7:0] stage2_reg, stage2_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [9:0] low_reg [2], low_next [2];
	logic [9:0] high_reg [2], high_next [2];
	logic [19:0] hold_reg [2], hold_next [2];
	logic [4:0] cfg_reg [2], cfg_next [2];
	logic wr, rd, access, in_map, port;
	logic [1:0] kind;
	logic [23:0] wword;
	logic [23:0] rword;

	// Strobes count only while the lower half select is low.
	assign wr = !select_lower_half_n_i && up_wr_i;
	assign rd = !select_lower_half_n_i && up_rd_i && !up_wr_i;
	assign access = sleep_reg[ild_pkg::SLEEP_ACCESS_BIT];
	assign in_map = channel_addr_pointer_reg <= ild_pkg::OFS_LAST;
	assign port = channel_addr_pointer_reg[2];
	assign kind = channel_addr_pointer_reg[1:0];
	assign wword = {stage2_reg, stage1_reg, up_wdata_i};

	// Register selected by the pointer, zero padded; unmapped pointers read zero.
	always_comb begin
		rword = 24'h000000;
		if (access && in_map) begin
			if (kind == ild_pkg::OFS_LOW_A[1:0]) begin
				rword = {14'h0000, low_reg[port]};
			end else if (kind == ild_pkg::OFS_HIGH_A[1:0]) begin
				rword = {14'h0000, high_reg[port]};
			end else if (kind == ild_pkg::OFS_HOLD_A[1:0]) begin
				rword = {4'h0, hold_reg[port]};
			end else begin
				rword = {19'h00000, cfg_reg[port]};
			end
		end
	end

	// Microport decode. A word commits on the write of its low byte, so the
	// upper bytes must be staged first; this keeps a 20-bit hold time from
	// being used half written.
	always_comb begin
		sleep_next = sleep_reg;
		channel_addr_pointer_next = channel_addr_pointer_reg;
		stage1_next = stage1_reg;
		stage2_next = stage2_reg;
		rdata_next = rdata_reg;
		for (int p = 0; p < 2; p++) begin
			low_next[p] = low_reg[p];
			high_next[p] = high_reg[p];
			hold_next[p] = hold_reg[p];
			cfg_next[p] = cfg_reg[p];
		end
		if (wr) begin
			if (up_addr_i == ild_pkg::EXT_SLEEP) begin
				sleep_next = up_wdata_i;
			end else if (up_addr_i == ild_pkg::EXT_CAR) begin
				channel_addr_pointer_next = up_wdata_i;
			end else if (up_addr_i == ild_pkg::EXT_DATA1) begin
				stage1_next = up_wdata_i;
			end else if (up_addr_i == ild_pkg::EXT_DATA2) begin
				stage2_next = up_wdata_i;
			end else if (up_addr_i == ild_pkg::EXT_DATA0 && access && in_map) begin
				// Port B sits four addresses above port A with the same layout.
				if (kind == ild_pkg::OFS_LOW_A[1:0]) begin
					low_next[port] = wword[9:0];
				end else if (kind == ild_pkg::OFS_HIGH_A[1:0]) begin
					high_next[port] = wword[9:0];
				end else if (kind == ild_pkg::OFS_HOLD_A[1:0]) begin
					hold_next[port] = wword[19:0];
				end else begin
					cfg_next[port] = wword[4:0];
				end
			end
		end
		if (rd) begin
			if (up_addr_i == ild_pkg::EXT_SLEEP) begin
				rdata_next = sleep_reg;
			end else if (up_addr_i == ild_pkg::EXT_CAR) begin
				rdata_next = channel_addr_pointer_reg;
			end else if (up_addr_i == ild_pkg::EXT_DATA0) begin
				rdata_next = rword[7:0];
			end else if (up_addr_i == ild_pkg::EXT_DATA1) begin
				rdata_next = rword[15:8];
			end else if (up_addr_i == ild_pkg::EXT_DATA2) begin
				rdata_next = rword[23:16];
			end else begin
				rdata_next = ild_pkg::RST_BYTE;
			end
		end
	end

	// Register file. Hold times clear at reset, which keeps detection off.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sleep_reg <= ild_pkg::RST_BYTE;
			channel_addr_pointer_reg <= ild_pkg::RST_BYTE;
			stage1_reg <= ild_pkg::RST_BYTE;
			stage2_reg <= ild_pkg::RST_BYTE;
			rdata_reg <= ild_pkg::RST_BYTE;
			for (int p = 0; p < 2; p++) begin
				low_reg[p] <= ild_pkg::RST_THR;
				high_reg[p] <= ild_pkg::RST_THR;
				hold_reg[p] <= ild_pkg::RST_HOLD;
				cfg_reg[p] <= ild_pkg::RST_CFG;
			end
		end else begin
			sleep_reg <= sleep_next;
			channel_addr_pointer_reg <= channel_addr_pointer_next;
			stage1_reg <= stage1_next;
			stage2_reg <= stage2_next;
			rdata_reg <= rdata_next;
			low_reg <= low_next;
			high_reg <= high_next;
			hold_reg <= hold_next;
			cfg_reg <= cfg_next;
		end
	end

	assign up_rdata_o = rdata_reg;

	// Port A detector.
	ild_port_detector u_port_a (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.sample_i(port_a_sample_i),
		.input_select_i(port_a_input_select_i),
		.low_level_i(low_reg[0]),
		.high_level_i(high_reg[0]),
		.hold_time_i(hold_reg[0]),
		.config_i(cfg_reg[0]),
		.level_out_first_o(port_a_level_out_first_o),
		.level_out_second_o(port_a_level_out_second_o)
	);

	// Port B detector, independent settings.
	ild_port_detector u_port_b (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.sample_i(port_b_sample_i),
		.input_select_i(port_b_input_select_i),
		.low_level_i(low_reg[1]),
		.high_level_i(high_reg[1]),
		.hold_time_i(hold_reg[1]),
		.config_i(cfg_reg[1]),
		.level_out_first_o(port_b_level_out_first_o),
		.level_out_second_o(port_b_level_out_second_o)
	);

	AST_NO_ACCESS: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		wr && !access |=> hold_reg[0] == $past(hold_reg[0]) && hold_reg[1] == $past(hold_reg[1]))
		else $error("Register written without the access bit.");
	AST_HOLD_WRITE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		wr && up_addr_i == 3'h0 && access && channel_addr_pointer_reg == 8'h06
		|=> hold_reg[1] == $past(wword[19:0]) && hold_reg[0] == $past(hold_reg[0]))
		else $error("Port B hold time write misrouted.");
	AST_DESELECT: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		select_lower_half_n_i |=> sleep_reg == $past(sleep_reg)
		&& channel_addr_pointer_reg == $past(channel_addr_pointer_reg))
		else $error("Write taken while deselected.");

	// Bus checks: every strobe lands only in the register that address and pointer name.
	AST_SLEEP_WRITE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		wr && up_addr_i == ild_pkg::EXT_SLEEP |=> sleep_reg == $past(up_wdata_i))
		else $error("Sleep register write lost.");
	AST_POINTER_WRITE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		wr && up_addr_i == ild_pkg::EXT_CAR |=> channel_addr_pointer_reg == $past(up_wdata_i))
		else $error("Pointer write lost.");
	AST_LOW_WRITE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		wr && up_addr_i == ild_pkg::EXT_DATA0 && access && channel_addr_pointer_reg == 8'h00
		|=> low_reg[0] == $past(wword[9:0]) && low_reg[1] == $past(low_reg[1]))
		else $error("Port A low level write misrouted.");
	AST_HIGH_WRITE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		wr && up_addr_i == ild_pkg::EXT_DATA0 && access && channel_addr_pointer_reg == 8'h05
		|=> high_reg[1] == $past(wword[9:0]) && high_reg[0] == $past(high_reg[0]))
		else $error("Port B high level write misrouted.");
	AST_CFG_WRITE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		wr && up_addr_i == ild_pkg::EXT_DATA0 && access && channel_addr_pointer_reg == 8'h03
		|=> cfg_reg[0] == $past(wword[4:0]) && cfg_reg[1] == $past(cfg_reg[1]))
		else $error("Port A config write misrouted.");
	AST_OUT_OF_MAP: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		wr && up_addr_i == ild_pkg::EXT_DATA0 && !in_map
		|=> low_reg[0] == $past(low_reg[0]) && high_reg[0] == $past(high_reg[0])
		&& hold_reg[0] == $past(hold_reg[0]) && cfg_reg[0] == $past(cfg_reg[0])
		&& low_reg[1] == $past(low_reg[1]) && high_reg[1] == $past(high_reg[1])
		&& hold_reg[1] == $past(hold_reg[1]) && cfg_reg[1] == $past(cfg_reg[1]))
		else $error("Pointer outside the map changed a register.");
	AST_STAGED_ONLY: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		wr && up_addr_i != ild_pkg::EXT_DATA0
		|=> hold_reg[0] == $past(hold_reg[0]) && hold_reg[1] == $past(hold_reg[1]))
		else $error("A staged byte committed a hold time.");
	AST_READ_HOLD: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		rd && up_addr_i == ild_pkg::EXT_DATA0 && access && channel_addr_pointer_reg == 8'h06
		|=> up_rdata_o == $past(hold_reg[1][7:0]))
		else $error("Port B hold time low byte read wrong.");
	AST_READ_UNMAPPED: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		rd && up_addr_i > ild_pkg::EXT_SLEEP && up_addr_i != ild_pkg::EXT_CAR
		|=> up_rdata_o == ild_pkg::RST_BYTE)
		else $error("Unmapped external address did not read zero.");
	AST_READ_STANDS: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!rd |=> up_rdata_o == $past(up_rdata_o))
		else $error("Read data changed without a read.");

endmodule

// >>> rtl/ild_pkg.sv
// What this block does
// - Lower level met when top ten sample bits are at or below the low level.
// - Top ten sample bits at or above the high level make the indicator active.
// - A high sample loads the 20-bit hold counter; after the high excursion, low samples count it down one per clock.
// - A sample above the low level reloads the counter; counting restarts when low again.
// - The indicator goes inactive only after a full hold time of low samples.
// - A hold time of zero disables detection; software programs at least one.
// - Config bit 4 clear drives active high; set drives active low.
// - Config bit 3 clear: first output carries detection, second its complement.
// - Config bit 3 set: input select low steers to first, high to second.
// - Config bits 2 to 0 delay the indicator outputs.
// - Port B has its own registers and drives its own pair of outputs.
package ild_pkg;

	// Field widths.
	localparam int unsigned THR_W = 10;
	localparam int unsigned HOLD_W = 20;
	localparam int unsigned CFG_W = 5;
	localparam int unsigned LAT_W = 3;
	localparam int unsigned LAT_DEPTH = 8;

	// External microport addresses.
	localparam logic [2:0] EXT_DATA0 = 3'h0;
	localparam logic [2:0] EXT_DATA1 = 3'h1;
	localparam logic [2:0] EXT_DATA2 = 3'h2;
	localparam logic [2:0] EXT_SLEEP = 3'h3;
	localparam logic [2:0] EXT_CAR = 3'h6;
	localparam int unsigned SLEEP_ACCESS_BIT = 5;

	// Channel addresses of the input port registers.
	localparam logic [7:0] OFS_LOW_A = 8'h00;
	localparam logic [7:0] OFS_HIGH_A = 8'h01;
	localparam logic [7:0] OFS_HOLD_A = 8'h02;
	localparam logic [7:0] OFS_CFG_A = 8'h03;
	localparam logic [7:0] OFS_PORT_B = 8'h04;
	localparam logic [7:0] OFS_LAST = 8'h07;

	// Indicator config fields.
	localparam int unsigned CFG_POL_BIT = 4;
	localparam int unsigned CFG_ILV_BIT = 3;
	localparam int unsigned CFG_LAT_MSB = 2;

	// Values after reset.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_THR = 10'h000;
	localparam logic [19:0] RST_HOLD = 20'h00000;
	localparam logic [4:0] RST_CFG = 5'h00;
	localparam logic [19:0] HOLD_ONE = 20'h00001;

	// Detector states.
	typedef enum logic {
		ILD_IDLE = 1'b0,
		ILD_HELD = 1'b1
	} ild_state_e;

endpackage

// >>> rtl/ild_port_detector.sv
`timescale 1ns/1ps
module ild_port_detector (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Sample and steering.
	input wire logic [9:0] sample_i,
	input wire logic input_select_i,
	// Settings.
	input wire logic [9:0] low_level_i,
	input wire logic [9:0] high_level_i,
	input wire logic [19:0] hold_time_i,
	input wire logic [4:0] config_i,
	// Indicator pair.
	output logic level_out_first_o,
	output logic level_out_second_o
);

	ild_pkg::ild_state_e state_reg, state_next;
	logic [19:0] cnt_reg, cnt_next;
	logic [1:0] hist_reg [1:ild_pkg::LAT_DEPTH-1];
	logic [1:0] hist_next [1:ild_pkg::LAT_DEPTH-1];
	logic first_reg, first_next, second_reg, second_next;
	logic at_low, at_high, active, pol, ilv;
	logic [2:0] lat;
	logic [1:0] tap;

	assign at_low = sample_i <= low_level_i;
	assign at_high = sample_i >= high_level_i;
	assign active = state_reg == ild_pkg::ILD_HELD;
	assign pol = config_i[ild_pkg::CFG_POL_BIT];
	assign ilv = config_i[ild_pkg::CFG_ILV_BIT];
	assign lat = config_i[ild_pkg::CFG_LAT_MSB:0];

	// Dwell tracking; a high sample wins over a low one if the levels overlap.
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		if (hold_time_i == ild_pkg::RST_HOLD) begin
			state_next = ild_pkg::ILD_IDLE;
			cnt_next = ild_pkg::RST_HOLD;
		end else if (at_high) begin
			state_next = ild_pkg::ILD_HELD;
			cnt_next = hold_time_i;
		end else if (active) begin
			if (!at_low) begin
				cnt_next = hold_time_i;
			end else if (cnt_reg <= ild_pkg::HOLD_ONE) begin
				state_next = ild_pkg::ILD_IDLE;
			end else begin
				cnt_next = cnt_reg - ild_pkg::HOLD_ONE;
			end
		end
	end

	// Delay line holds detection and steering so both stay aligned.
	always_comb begin
		hist_next[1] = {active, input_select_i};
		for (int k = 2; k < ild_pkg::LAT_DEPTH; k++) begin
			hist_next[k] = hist_reg[k-1];
		end
		tap = (lat == 3'h0) ? {active, input_select_i} : hist_reg[lat];
		if (ilv) begin
			first_next = (tap[1] & ~tap[0]) ^ pol;
			second_next = (tap[1] & tap[0]) ^ pol;
		end else begin
			first_next = tap[1] ^ pol;
			second_next = ~tap[1] ^ pol;
		end
	end

	// Registers; all but the second output clear at reset (it sets), so the first output starts inactive.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ild_pkg::ILD_IDLE;
			cnt_reg <= ild_pkg::RST_HOLD;
			for (int k = 1; k < ild_pkg::LAT_DEPTH; k++) begin
				hist_reg[k] <= 2'h0;
			end
			first_reg <= 1'b0;
			second_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			hist_reg <= hist_next;
			first_reg <= first_next;
			second_reg <= second_next;
		end
	end

	assign level_out_first_o = first_reg;
	assign level_out_second_o = second_reg;

	AST_HIGH_SETS: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		at_high && hold_time_i != 20'h00000 |=> state_reg == ild_pkg::ILD_HELD && cnt_reg == $past(hold_time_i))
		else $error("High sample did not arm the indicator.");
	AST_ZERO_OFF: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		hold_time_i == 20'h00000 |=> state_reg == ild_pkg::ILD_IDLE)
		else $error("Zero hold time did not disable detection.");
	AST_COUNT_DOWN: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		active && at_low && !at_high && cnt_reg > 20'h00001 && hold_time_i != 20'h00000
		|=> active && cnt_reg == $past(cnt_reg) - 20'h00001)
		else $error("Hold counter did not count a low sample.");
	AST_RELOAD: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		active && !at_low && !at_high && hold_time_i != 20'h00000
		|=> active && cnt_reg == $past(hold_time_i))
		else $error("Hold counter not reloaded above the low level.");
	AST_RELEASE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		active && at_low && !at_high && cnt_reg == 20'h00001 |=> !active)
		else $error("Indicator not released after the hold time.");
	AST_STAY: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!active && !(at_high && hold_time_i != 20'h00000) |=> !active)
		else $error("Indicator became active without a high sample.");
	AST_COMPLEMENT: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!ilv |=> level_out_second_o == !level_out_first_o)
		else $error("Second output is not the complement in single mode.");
	AST_NO_DELAY: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		config_i[3:0] == 4'h0 |=> level_out_first_o == ($past(active) ^ $past(pol)))
		else $error("Indicator does not follow detection with its polarity.");
	AST_STEER: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		config_i == 5'h08 |=> level_out_second_o == $past(active && input_select_i))
		else $error("Interleaved steering wrong.");
	AST_DELAY3: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		config_i[2:0] == 3'h3 && !ilv ##0 $past(rstn_i, 4)
		|=> level_out_first_o == ($past(active, 4) ^ $past(pol)))
		else $error("Delay of three cycles not applied.");

endmodule

// >>> test/ild_gain_stage.sv
`timescale 1ns/1ps
// Attenuator pad ahead of the converter, switched by one indicator pin.
module ild_gain_stage (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Indicator pin and its active level.
	input wire logic level_i,
	input wire logic active_low_i,
	// Pad state and number of pad switches.
	output logic attn_o,
	output logic [7:0] switches_o
);
	// The pad follows the pin one clock late; every change is counted, so a glitch shows up.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			attn_o <= 1'b0;
			switches_o <= 8'h00;
		end else begin
			attn_o <= level_i ^ active_low_i;
			if ((level_i ^ active_low_i) != attn_o) begin
				switches_o <= switches_o + 8'h01;
			end
		end
	end
endmodule

// >>> test/ild_input_level_detector_bench.sv
`timescale 1ns/1ps
module ild_input_level_detector_bench;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic cs_n = 1'b1;
	logic [2:0] addr = 3'h0;
	logic up_wr = 1'b0;
	logic up_rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [9:0] samp [0:1] = '{10'h000, 10'h000};
	logic sel [0:1] = '{1'b0, 1'b0};
	wire [3:0] outs;
	logic attn;
	logic [7:0] sw;
	int n_fail = 0;
	int compares = 0;

	// Sample clock, 25 MHz.
	always #20 mclk_i = ~mclk_i;

	ild_input_level_detector u_ild_input_level_detector (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .select_lower_half_n_i(cs_n), .up_addr_i(addr),
		.up_wr_i(up_wr), .up_rd_i(up_rd), .up_wdata_i(wdata), .up_rdata_o(rdata),
		.port_a_sample_i(samp[0]), .port_a_input_select_i(sel[0]),
		.port_a_level_out_first_o(outs[0]), .port_a_level_out_second_o(outs[1]),
		.port_b_sample_i(samp[1]), .port_b_input_select_i(sel[1]),
		.port_b_level_out_first_o(outs[2]), .port_b_level_out_second_o(outs[3])
	);

	// The pad sits on the first indicator of port A; it is judged only while that port is active high.
	ild_gain_stage u_ild_gain_stage (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .level_i(outs[0]), .active_low_i(1'b0),
		.attn_o(attn), .switches_o(sw)
	);

	// Compare, count and report one value.
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Print the counts and the verdict, then end the run.
	task automatic stop_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// One microport write, held for exactly one sampling edge.
	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		cs_n <= 1'b0;
		addr <= a;
		wdata <= d;
		up_wr <= 1'b1;
		@(posedge mclk_i);
		cs_n <= 1'b1;
		up_wr <= 1'b0;
	endtask

	// One microport read; the registered data is taken a cycle after the read edge.
	task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		cs_n <= 1'b0;
		addr <= a;
		up_rd <= 1'b1;
		@(posedge mclk_i);
		cs_n <= 1'b1;
		up_rd <= 1'b0;
		@(posedge mclk_i);
		#1;
		d = rdata;
	endtask

	// Open the input port space, aim the pointer, then send byte 2, 1 and the committing byte 0.
	task automatic set_reg(input logic [7:0] ofs, input logic [23:0] w);
		bus_wr(3'h3, 8'h20);
		bus_wr(3'h6, ofs);
		bus_wr(3'h2, w[23:16]);
		bus_wr(3'h1, w[15:8]);
		bus_wr(3'h0, w[7:0]);
	endtask

	// Same opening sequence, then the three data bytes are read back.
	task automatic get_reg(input logic [7:0] ofs, output logic [23:0] w);
		bus_wr(3'h3, 8'h20);
		bus_wr(3'h6, ofs);
		bus_rd(3'h2, w[23:16]);
		bus_rd(3'h1, w[15:8]);
		bus_rd(3'h0, w[7:0]);
	endtask

	// Program one port and give the outputs time to settle through any latency.
	task automatic cfg_port(input int p, input logic [19:0] hold, input logic [4:0] cfg);
		logic [7:0] b;
		b = (p == 1) ? 8'h04 : 8'h00;
		set_reg(b, 24'h000032);
		set_reg(b + 8'h01, 24'h000064);
		set_reg(b + 8'h02, {4'h0, hold});
		set_reg(b + 8'h03, {19'h00000, cfg});
		repeat (10) @(posedge mclk_i);
	endtask

	// Count edges until an indicator reaches a level; a bounded wait, never open-ended.
	task automatic wait_bit(input int idx, input logic val, input int expn);
		int n;
		n = 0;
		do begin
			@(posedge mclk_i);
			#1;
			n++;
		end while (outs[idx] !== val && n < 60);
		if (outs[idx] !== val) begin
			n_fail++;
			$display("Error indicator %0d expected %b seen %b", idx, val, outs[idx]);
			stop_test();
		end
		check("indicator edge count", 24'(expn), 24'(n));
	endtask

	// One excursion: a sample exactly at the high level, then samples exactly at the low level.
	task automatic detect(input int p, input int hold, input logic [4:0] cfg, input logic s,
		input bit reload);
		int a;
		int lat;
		a = 2 * p + ((cfg[3] && s) ? 1 : 0);
		lat = int'(cfg[2:0]);
		@(posedge mclk_i);
		samp[p] <= 10'h064;
		@(posedge mclk_i);
		samp[p] <= 10'h032;
		// The high sample is taken one edge after it is driven; the pin follows one edge plus the configured latency later.
		wait_bit(a, ~cfg[4], 1 + lat);
		check("other indicator", {23'h000000, cfg[4]}, {23'h000000, outs[a ^ 1]});
		if (reload) begin
			@(posedge mclk_i);
			samp[p] <= 10'h033;
			@(posedge mclk_i);
			samp[p] <= 10'h032;
			wait_bit(a, cfg[4], 1 + hold + lat);
		end else begin
			wait_bit(a, cfg[4], hold);
		end
	endtask

	// Reset values, read back of every field width, and accesses that must be refused.
	task automatic regs_test;
		logic [23:0] w;
		logic [7:0] b;
		for (int i = 0; i < 8; i++) begin
			get_reg(8'(i), w);
			check("register after reset", 24'h000000, w);
		end
		for (int i = 0; i < 8; i++) begin
			set_reg(8'(i), 24'hFFFFFF);
			get_reg(8'(i), w);
			check("register read back", (i % 4 == 2) ? 24'h0FFFFF : (i % 4 == 3) ? 24'h00001F : 24'h0003FF, w);
		end
		bus_wr(3'h3, 8'h00);
		bus_wr(3'h6, 8'h00);
		bus_wr(3'h0, 8'h55);
		get_reg(8'h00, w);
		check("write with access closed", 24'h0003FF, w);
		set_reg(8'h09, 24'h000055);
		get_reg(8'h09, w);
		check("pointer past the port map", 24'h000000, w);
		bus_rd(3'h5, b);
		check("unmapped external address", 24'h000000, {16'h0000, b});
	endtask

	// Single mode on both ports; the pad must switch once in and once out.
	task automatic single_test;
		logic [7:0] sw0;
		cfg_port(0, 6, 5'h00);
		cfg_port(1, 3, 5'h00);
		sw0 = sw;
		detect(0, 6, 5'h00, 1'b0, 1'b1);
		// The pad takes the pin one edge late, so that edge must pass before counting.
		@(posedge mclk_i);
		#1;
		check("pad switches", 24'h000002, {16'h0000, sw - sw0});
	endtask

	// Active low indicator with three cycles of latency.
	task automatic polarity_test;
		cfg_port(0, 6, 5'h13);
		check("idle level active low", 24'h000001, {23'h000000, outs[0]});
		detect(0, 6, 5'h13, 1'b0, 1'b0);
	endtask

	// Interleaved input, steered by the select pin in both of its states.
	task automatic steer_test;
		@(posedge mclk_i);
		sel[0] <= 1'b1;
		cfg_port(0, 4, 5'h08);
		detect(0, 4, 5'h08, 1'b1, 1'b0);
		@(posedge mclk_i);
		sel[0] <= 1'b0;
		repeat (4) @(posedge mclk_i);
		detect(0, 4, 5'h08, 1'b0, 1'b0);
	endtask

	// Port B on its own, a sample one under the high level, then a hold time of zero.
	task automatic port_b_test;
		detect(1, 3, 5'h00, 1'b0, 1'b0);
		check("port A idle beside port B", 24'h000000, {22'h000000, outs[1:0]});
		@(posedge mclk_i);
		samp[1] <= 10'h063;
		repeat (8) @(posedge mclk_i);
		#1;
		check("sample just under the high level", 24'h000002, {22'h000000, outs[3:2]});
		set_reg(8'h06, 24'h000000);
		@(posedge mclk_i);
		samp[1] <= 10'h3FF;
		repeat (8) @(posedge mclk_i);
		#1;
		check("hold time zero", 24'h000002, {22'h000000, outs[3:2]});
	endtask

	initial begin
		repeat (20) @(posedge mclk_i);
		rstn_i <= 1'b1;
		@(posedge mclk_i);
		#1;
		check("indicators after reset", 24'h00000A, {20'h00000, outs});
		regs_test();
		single_test();
		polarity_test();
		steer_test();
		port_b_test();
		stop_test();
	end
endmodule
